// ### hw/cfgs_status.v
// Read-only configuration status register for the configuration port.
// Assumes all status sources arrive on core_clk_i except the pins and straps.
//
// What this block does
// - Bus width field at bits 26 to 25.
// - Parallel modes load x8 after strap sampling.
// - Access port width shown after configuration.
// - Authentication forces width to thirty-two.
// - Start-up phase Gray coded at 20:18.
// - Bit 15 flags frame write without check.
// - Bit 14 shows completion pin level.
// - Bit 13 shows completion pin release.
// - Bit 12 shows initialization pin level.
// - Bit 11 shows initialization finished.
// - Bits 10 to 8 show mode straps.
// - Bit 6 shows global write enable.
// - Bit 5 shows I/O tri-state release.
// - Bit 4 shows start-up finished.
// - Bit 3 ANDs bank calibration matches.
// - Bit 2 ANDs clock generator locks.
// - Bit 1 shows decryption security set.
// - Host reads return current flag values.
`timescale 1ns/10ps
`include "cfgs_consts.vh"
module cfgs_status (
    // Clock and reset.
    input  wire        core_clk_i,
    input  wire        reset_i,
    // Host read port.
    input  wire        rd_en_i,
    input  wire        wr_en_i,
    input  wire [31:0] wr_data_i,
    output reg  [31:0] rd_data_o,
    output wire        rd_valid_o,
    // External pins and straps.
    input  wire        done_pin_i,
    input  wire        init_pin_i,
    input  wire [2:0]  mode_pins_i,
    // Width sources.
    input  wire        straps_sampled_i,
    input  wire        parallel_mode_i,
    input  wire        width_detect_valid_i,
    input  wire [1:0]  width_detect_i,
    input  wire        access_port_en_i,
    input  wire [1:0]  access_port_width_i,
    input  wire        config_done_i,
    input  wire        rsa_auth_i,
    // Start-up and global states.
    input  wire [2:0]  startup_phase_i,
    input  wire        frame_write_i,
    input  wire        id_check_ok_i,
    input  wire        done_release_i,
    input  wire        init_done_i,
    input  wire        global_write_en_i,
    input  wire        io_release_i,
    input  wire        startup_finished_i,
    input  wire [7:0]  bank_cal_match_i,
    input  wire [7:0]  bank_has_cal_i,
    input  wire [7:0]  clk_gen_locked_i,
    input  wire [7:0]  clk_gen_used_i,
    input  wire        decrypt_set_i,
    input  wire        over_temp_i,
    input  wire        security_err_i,
    input  wire        crc_err_i,
    // Status snapshot.
    output wire [31:0] status_o
);
    reg  [1:0]  bus_width;
    reg  [1:0]  next_bus_width;
    reg         id_mismatch;
    reg         rd_pend;
    reg  [31:0] stat;
    wire [1:0]  pins_q;
    wire [2:0]  mode_q;
    wire [2:0]  phase_code;
    wire [7:0]  cal_terms;
    wire [7:0]  lock_terms;
    wire        cal_all;
    wire        lock_all;
    genvar g;

    // Pins and straps come from outside the clock domain.
    cfgs_sync #(
        .W (2)
    ) u_pin_sync (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .async_i    ({done_pin_i, init_pin_i}),
        .level_o    (pins_q)
    );

    cfgs_sync #(
        .W (3)
    ) u_mode_sync (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .async_i    (mode_pins_i),
        .level_o    (mode_q)
    );

    // Phase encoder.
    cfgs_gray u_gray (
        .phase_i (startup_phase_i),
        .code_o  (phase_code)
    );

    // Banks without calibration and unused generators count as matched.
    generate
        for (g = 0; g < `CFGS_NUM_BANKS; g = g + 1) begin : terms
            assign cal_terms[g]  = bank_cal_match_i[g] | ~bank_has_cal_i[g];
            assign lock_terms[g] = clk_gen_locked_i[g] | ~clk_gen_used_i[g];
        end
    endgenerate
    assign cal_all  = &cal_terms;
    assign lock_all = &lock_terms;

    // Width selection; authentication wins over every other source.
    always @* begin
        next_bus_width = bus_width;
        if (rsa_auth_i) begin
            next_bus_width = `CFGS_BW_X32;
        end else if (access_port_en_i && config_done_i) begin
            next_bus_width = access_port_width_i;
        end else if (width_detect_valid_i) begin
            next_bus_width = width_detect_i;
        end else if (straps_sampled_i && parallel_mode_i) begin
            next_bus_width = `CFGS_BW_X8;
        end
    end

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            bus_width <= `CFGS_BW_X1;
        end else begin
            bus_width <= next_bus_width;
        end
    end

    // Identity error is sticky until configuration reset.
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            id_mismatch <= 1'b0;
        end else if (frame_write_i && !id_check_ok_i) begin
            id_mismatch <= 1'b1;
        end
    end

    // Assemble the word; unnamed positions stay zero.
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            stat <= `CFGS_STAT_RESET;
        end else begin
            stat <= 32'h00000000;
            stat[`CFGS_WIDTH_MSB:`CFGS_WIDTH_LSB] <= bus_width;
            stat[`CFGS_PHASE_MSB:`CFGS_PHASE_LSB] <= phase_code;
            stat[`CFGS_OVERTEMP_BIT] <= over_temp_i;
            stat[`CFGS_SECURITY_BIT] <= security_err_i;
            stat[`CFGS_IDERR_BIT]    <= id_mismatch;
            stat[`CFGS_DONE_PIN_BIT] <= pins_q[1];
            stat[`CFGS_DONE_INT_BIT] <= done_release_i;
            stat[`CFGS_INIT_PIN_BIT] <= pins_q[0];
            stat[`CFGS_INIT_INT_BIT] <= init_done_i;
            stat[`CFGS_MODE_MSB:`CFGS_MODE_LSB] <= mode_q;
            stat[`CFGS_GWE_BIT]      <= global_write_en_i;
            stat[`CFGS_GTS_BIT]      <= io_release_i;
            stat[`CFGS_EOS_BIT]      <= startup_finished_i;
            stat[`CFGS_CAL_BIT]      <= cal_all;
            stat[`CFGS_LOCK_BIT]     <= lock_all;
            stat[`CFGS_DEC_BIT]      <= decrypt_set_i;
            stat[`CFGS_CRC_BIT]      <= crc_err_i;
        end
    end

    // Read returns the word one cycle after the request; writes are dropped.
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            rd_data_o <= 32'h00000000;
            rd_pend   <= 1'b0;
        end else begin
            rd_pend <= rd_en_i;
            if (rd_en_i) begin
                rd_data_o <= stat;
            end
        end
    end

    // Write strobe and data are accepted and ignored by design.
    assign rd_valid_o = rd_pend;
    assign status_o   = stat;
endmodule

// ### hw/cfgs_consts.vh
// Constants for the configuration status register block.
// Assumes inclusion by bare name from the design files.
`ifndef CFGS_CONSTS_VH
`define CFGS_CONSTS_VH
`define CFGS_WIDTH_LSB      25
`define CFGS_WIDTH_MSB      26
`define CFGS_PHASE_LSB      18
`define CFGS_PHASE_MSB      20
`define CFGS_OVERTEMP_BIT   17
`define CFGS_SECURITY_BIT   16
`define CFGS_IDERR_BIT      15
`define CFGS_DONE_PIN_BIT   14
`define CFGS_DONE_INT_BIT   13
`define CFGS_INIT_PIN_BIT   12
`define CFGS_INIT_INT_BIT   11
`define CFGS_MODE_LSB       8
`define CFGS_MODE_MSB       10
`define CFGS_GWE_BIT        6
`define CFGS_GTS_BIT        5
`define CFGS_EOS_BIT        4
`define CFGS_CAL_BIT        3
`define CFGS_LOCK_BIT       2
`define CFGS_DEC_BIT        1
`define CFGS_CRC_BIT        0
`define CFGS_BW_X1          2'h0
`define CFGS_BW_X8          2'h1
`define CFGS_BW_X16         2'h2
`define CFGS_BW_X32         2'h3
`define CFGS_STAT_RESET     32'h00000000
`define CFGS_NUM_BANKS      8
`define CFGS_NUM_CLKGEN     8
`endif

// ### hw/cfgs_sync.v
// Three-stage synchroniser bank for pins from outside the clock domain.
// Assumes one clock; a change is accepted once stages two and three agree.
`timescale 1ns/10ps
module cfgs_sync #(
    parameter W = 1
) (
    // Clock and reset.
    input  wire         core_clk_i,
    input  wire         reset_i,
    // Raw and filtered levels.
    input  wire [W-1:0] async_i,
    output reg  [W-1:0] level_o
);
    reg [W-1:0] stage1;
    reg [W-1:0] stage2;
    reg [W-1:0] stage3;
    genvar g;

    // Stage one feeds only stage two, so metastability never reaches logic.
    generate
        for (g = 0; g < W; g = g + 1) begin : bit_sync
            always @(posedge core_clk_i) begin
                if (reset_i) begin
                    stage1[g]  <= 1'b0;
                    stage2[g]  <= 1'b0;
                    stage3[g]  <= 1'b0;
                    level_o[g] <= 1'b0;
                end else begin
                    stage1[g] <= async_i[g];
                    stage2[g] <= stage1[g];
                    stage3[g] <= stage2[g];
                    if (stage2[g] == stage3[g]) begin
                        level_o[g] <= stage3[g];
                    end
                end
            end
        end
    endgenerate
endmodule

// ### hw/cfgs_gray.v
// Binary to Gray encoder for the start-up phase number.
// Assumes the phase number is a registered value on the same clock.
`timescale 1ns/10ps
module cfgs_gray (
    // Phase number in binary.
    input  wire [2:0] phase_i,
    // Phase in Gray code.
    output wire [2:0] code_o
);
    // Adjacent phases differ in one bit, so a torn read is off by one phase.
    assign code_o = phase_i ^ {1'b0, phase_i[2:1]};
endmodule

// ### tb/cfgs_status_assertions.sv
// Checker for the configuration status word, bound to cfgs_status.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module cfgs_status_chk (
    input wire        core_clk_i,
    input wire        reset_i,
    input wire        rd_en_i,
    input wire        rd_valid_o,
    input wire [31:0] rd_data_o,
    input wire [31:0] status_o,
    input wire [2:0]  startup_phase_i,
    input wire        rsa_auth_i,
    input wire [7:0]  clk_gen_locked_i,
    input wire [7:0]  clk_gen_used_i,
    input wire        over_temp_i,
    input wire        security_err_i,
    input wire        decrypt_set_i,
    input wire        crc_err_i
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    // A read is a request edge followed by an answer edge carrying the word.
    sequence s_req;
        rd_en_i;
    endsequence
    sequence s_ans;
        rd_valid_o && rd_data_o == $past(status_o);
    endsequence
    chk_read_answer: assert property (s_req |=> s_ans)
        else $error("Read request not answered with the status word.");
    chk_valid_cause: assert property (!rd_en_i |=> !rd_valid_o)
        else $error("Read answer without a request.");
    chk_read_hold: assert property (!$past(rd_en_i) && !$past(reset_i) |-> $stable(rd_data_o))
        else $error("Read data changed without a read.");
    chk_flag_bits: assert property (!$past(reset_i) |-> status_o[1] == $past(decrypt_set_i)
        && status_o[0] == $past(crc_err_i) && status_o[17] == $past(over_temp_i)
        && status_o[16] == $past(security_err_i))
        else $error("Live flag bits do not follow their sources.");
    chk_phase_gray: assert property (!$past(reset_i) |-> status_o[20:18] ==
        ($past(startup_phase_i) ^ ($past(startup_phase_i) >> 1)))
        else $error("Start-up phase code is not Gray.");
    chk_lock_and: assert property (!$past(reset_i) |-> status_o[2] ==
        &($past(clk_gen_locked_i) | ~$past(clk_gen_used_i)))
        else $error("Lock bit is not the AND of used generators.");
    chk_reserved_zero: assert property ((status_o & 32'hf9e00080) == 32'h0)
        else $error("Reserved status bit set.");
    chk_width_rsa: assert property ((!reset_i && rsa_auth_i)[*3] |-> status_o[26:25] == 2'h3)
        else $error("Authentication did not force the widest bus.");
endmodule
bind cfgs_status cfgs_status_chk u_chk (.*);

// ### tb/cfgs_host_model.sv
// Host model reading the status word through the read port.
// Assumes the answer arrives within a few cycles of the request edge.
`timescale 1ns/10ps
module cfgs_host_model (
    // Clock and answer.
    input  wire        core_clk_i,
    input  wire        rd_valid_o,
    input  wire [31:0] rd_data_o,
    // Request.
    output reg         rd_en_i
);
    initial rd_en_i = 1'b0;
    // One request edge, then a bounded wait; sampling 1 ns after edges avoids races.
    task read_word(output logic [31:0] d, output logic ok);
        int n;
        ok = 1'b0;
        d = 32'h0;
        @(posedge core_clk_i);
        #1 rd_en_i = 1'b1;
        @(posedge core_clk_i);
        #1 rd_en_i = 1'b0;
        for (n = 0; n < 4 && !ok; n++) begin
            if (rd_valid_o === 1'b1) begin
                d = rd_data_o;
                ok = 1'b1;
            end else begin
                @(posedge core_clk_i);
                #1;
            end
        end
    endtask
endmodule

// ### tb/config_status_register_tb_top.sv
// Self-checking bench for the configuration status register.
// Assumes the host model makes every read; all other inputs are driven here.
`timescale 1ns/10ps
module config_status_register_tb_top;
    reg         core_clk_i = 1'b0, reset_i = 1'b1, wr_en_i = 1'b0;
    reg  [31:0] wr_data_i = 32'h0;
    reg  [2:0]  mode_pins_i = 3'h0, startup_phase_i = 3'h0;
    reg  [1:0]  width_detect_i = 2'h0, access_port_width_i = 2'h0;
    reg  [7:0]  bank_cal_match_i = 8'h0, bank_has_cal_i = 8'h0;
    reg  [7:0]  clk_gen_locked_i = 8'h0, clk_gen_used_i = 8'h0;
    reg         done_pin_i = 1'b0, init_pin_i = 1'b0, straps_sampled_i = 1'b0;
    reg         parallel_mode_i = 1'b0, width_detect_valid_i = 1'b0, access_port_en_i = 1'b0;
    reg         config_done_i = 1'b0, rsa_auth_i = 1'b0, frame_write_i = 1'b0;
    reg         id_check_ok_i = 1'b0, done_release_i = 1'b0, init_done_i = 1'b0;
    reg         global_write_en_i = 1'b0, io_release_i = 1'b0, startup_finished_i = 1'b0;
    reg         decrypt_set_i = 1'b0, over_temp_i = 1'b0, security_err_i = 1'b0, crc_err_i = 1'b0;
    wire [31:0] rd_data_o, status_o;
    wire        rd_valid_o, rd_en_i;
    int         bad_count = 0, checks_done = 0, i;
    logic [31:0] d;
    logic       ok;
    // Rows: phase, flags {over-temp, security, decrypt, crc}, expected Gray code.
    logic [9:0] rows [8] = '{10'h000, 10'h089, 10'h113, 10'h1a2,
                             10'h246, 10'h2ff, 10'h355, 10'h3ac};

    cfgs_status u_cfgs_status (.*);
    cfgs_host_model u_host (.*);

    // Free-running 25 MHz clock.
    always #20 core_clk_i = ~core_clk_i;

    task complete_run;
        if (bad_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task chk(input string nm, input [31:0] e, input [31:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Six idle edges let the pin synchroniser and the width pipeline settle first.
    task rdchk(input string nm, input [31:0] m, input [31:0] e);
        repeat (6) @(posedge core_clk_i);
        u_host.read_word(d, ok);
        if (ok !== 1'b1) begin
            $display("[FAIL] %s answer expected 1 seen 0", nm);
            bad_count++;
            complete_run;
        end
        chk(nm, e, d & m);
    endtask

    task tick;
        @(posedge core_clk_i);
        #1;
    endtask

    // Main sequence: reset, table of phases and flags, then hand-written cases.
    initial begin
        repeat (15) tick;
        chk("reset status", 32'h0, status_o);
        tick;
        reset_i = 1'b0;
        rdchk("idle word", 32'hffffffff, 32'h0000000c);
        wr_en_i = 1'b1;
        wr_data_i = 32'hffffffff;
        for (i = 0; i < 8; i++) begin
            startup_phase_i = rows[i][9:7];
            {over_temp_i, security_err_i, decrypt_set_i, crc_err_i} = rows[i][6:3];
            rdchk("phase and flags", 32'h001f0003,
                  {11'h0, rows[i][2:0], rows[i][6:5], 14'h0, rows[i][4:3]});
        end
        wr_en_i = 1'b0;
        bank_has_cal_i = 8'h81;
        bank_cal_match_i = 8'h01;
        clk_gen_used_i = 8'h03;
        clk_gen_locked_i = 8'h05;
        rdchk("cal and lock", 32'h0000000c, 32'h0);
        {done_pin_i, init_pin_i, mode_pins_i} = 5'h1d;
        {done_release_i, init_done_i, global_write_en_i, io_release_i} = 4'hf;
        startup_finished_i = 1'b1;
        rdchk("pins high", 32'h00007f70, 32'h00007d70);
        done_pin_i = 1'b0;
        rdchk("done held low", 32'h00007f70, 32'h00003d70);
        {straps_sampled_i, parallel_mode_i} = 2'h3;
        rdchk("width strap", 32'h06000000, 32'h02000000);
        {width_detect_valid_i, width_detect_i} = 3'h6;
        rdchk("width detect", 32'h06000000, 32'h04000000);
        {access_port_en_i, config_done_i} = 2'h3;
        rdchk("width access", 32'h06000000, 32'h0);
        rsa_auth_i = 1'b1;
        rdchk("width rsa", 32'h06000000, 32'h06000000);
        {frame_write_i, id_check_ok_i} = 2'h3;
        tick;
        frame_write_i = 1'b0;
        rdchk("id ok", 32'h00008000, 32'h0);
        {frame_write_i, id_check_ok_i} = 2'h2;
        tick;
        frame_write_i = 1'b0;
        rdchk("id error", 32'h00008000, 32'h00008000);
        reset_i = 1'b1;
        tick;
        tick;
        chk("mid reset status", 32'h0, status_o);
        chk("mid reset data", 32'h0, rd_data_o);
        chk("mid reset valid", 32'h0, {31'h0, rd_valid_o});
        reset_i = 1'b0;
        rdchk("id after reset", 32'h00008000, 32'h0);
        complete_run;
    end
endmodule
